// ===== rtl/event_status_aggregator_upper.v
// event status aggregator for bits 5 to 2 of the interrupt status word, with axi4-lite register access
// assumes buffer, detector and orientation inputs come from logic on aclk, so no synchronisers
// also holds the small flag cell shared by the three source flags
`timescale 1ns/1ns
`include "event_status_aggregator_upper_regs.vh"

module event_status_aggregator_upper (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire buffer_watermark_flag,
  input wire buffer_overflow_flag,
  input wire buffer_gate_error_flag,
  input wire buffer_full_flag,
  input wire outside_condition,
  input wire within_condition,
  input wire orientation_change,
  output wire [1:0] buffer_mode,
  output reg irq,
  output reg interrupt_pin_a,
  output reg interrupt_pin_b
);

  reg [1:0] buffer_mode_reg;
  reg outside_latch_enable;
  reg within_latch_enable;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  reg [3:0] irq_route;
  reg [3:0] prev_events;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  reg [1:0] next_bresp;

  wire buffer_enabled;
  wire watermark_counts;
  wire buffer_event_summary;
  wire [7:0] interrupt_event_status;
  wire [3:0] events;
  wire [3:0] active_irq;
  wire rd_take;
  wire wr_do;
  wire rd_src1;
  wire rd_src2;
  wire rd_orientation_engine;
  wire rd_irq_status;
  wire outside_event_active;
  wire within_event_active;
  wire new_orientation_indicator;
  wire [3:0] next_irq_status;
  wire next_irq;
  wire next_pin_a;
  wire next_pin_b;

  assign buffer_mode = buffer_mode_reg;

  assign buffer_enabled = (buffer_mode_reg != `BUFFER_MODE_DISABLED);
  assign watermark_counts = buffer_watermark_flag && (buffer_mode_reg != `BUFFER_MODE_TRIGGERED);
  // while enabled, or of buffer flags, full included, watermark left out in triggered mode
  assign buffer_event_summary = buffer_enabled &&
    (watermark_counts || buffer_overflow_flag || buffer_gate_error_flag || buffer_full_flag);

  // bits 5..2 placed, other bits belong to blocks elsewhere and read zero
  // bit 2 from new orientation indicator
  assign interrupt_event_status = {2'h0, buffer_event_summary, outside_event_active,
    within_event_active, new_orientation_indicator, 2'h0};
  // event order 3..0: summary, outside, within, orientation
  assign events = interrupt_event_status[5:2];

  // no second read is taken while its answer waits
  assign s_axi_arready = !s_axi_rvalid;
  // both write channels stay shut while the response waits, so one write at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_do = aw_held && w_held && !s_axi_bvalid;

  // read side effects fire once, on the cycle the address is taken
  assign rd_src1 = rd_take && (s_axi_araddr == `ADDR_DETECTOR_SOURCE1);
  assign rd_src2 = rd_take && (s_axi_araddr == `ADDR_DETECTOR_SOURCE2);
  assign rd_orientation_engine = rd_take && (s_axi_araddr == `ADDR_ORIENTATION_STATUS);
  assign rd_irq_status = rd_take && (s_axi_araddr == `ADDR_IRQ_STATUS);

  // rising edges of the status bits become sticky interrupt events
  assign active_irq = irq_status & irq_mask;

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `RESP_OKAY;
    case (s_axi_araddr)
      // status word read has no side effect
      `ADDR_INTERRUPT_EVENT_STATUS: next_rdata = {24'h00_0000, interrupt_event_status};
      // buffer detail and gate error readable
      `ADDR_BUFFER_STATUS: next_rdata = {29'h0000_0000, buffer_full_flag, buffer_overflow_flag,
        buffer_watermark_flag};
      `ADDR_SYSTEM_MODE: next_rdata = {31'h0000_0000, buffer_gate_error_flag};
      `ADDR_BUFFER_CONFIG1: next_rdata = {30'h0000_0000, buffer_mode_reg};
      `ADDR_DETECTOR_CONFIG1: next_rdata = {30'h0000_0000, within_latch_enable, outside_latch_enable};
      `ADDR_DETECTOR_SOURCE1: next_rdata = {31'h0000_0000, outside_event_active};
      `ADDR_DETECTOR_SOURCE2: next_rdata = {31'h0000_0000, within_event_active};
      `ADDR_ORIENTATION_STATUS: next_rdata = {31'h0000_0000, new_orientation_indicator};
      `ADDR_IRQ_STATUS: next_rdata = {28'h000_0000, irq_status};
      `ADDR_IRQ_MASK: next_rdata = {28'h000_0000, irq_mask};
      `ADDR_IRQ_ROUTE: next_rdata = {28'h000_0000, irq_route};
      default: next_rresp = `RESP_SLVERR;
    endcase
  end

  always @* begin
    next_bresp = `RESP_OKAY;
    case (aw_addr)
      `ADDR_INTERRUPT_EVENT_STATUS, `ADDR_BUFFER_STATUS, `ADDR_SYSTEM_MODE, `ADDR_BUFFER_CONFIG1,
      `ADDR_DETECTOR_CONFIG1, `ADDR_DETECTOR_SOURCE1, `ADDR_DETECTOR_SOURCE2,
      `ADDR_ORIENTATION_STATUS, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_IRQ_ROUTE:
        next_bresp = `RESP_OKAY;
      default: next_bresp = `RESP_SLVERR;
    endcase
  end

  // write channel: address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      buffer_mode_reg <= `RESET_BUFFER_MODE;
      outside_latch_enable <= 1'b0;
      within_latch_enable <= 1'b0;
      irq_mask <= `RESET_IRQ_MASK;
      irq_route <= `RESET_IRQ_ROUTE;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= next_bresp;
        if (w_strb[0]) begin
          case (aw_addr)
            `ADDR_BUFFER_CONFIG1: buffer_mode_reg <= w_data[1:0];
            `ADDR_DETECTOR_CONFIG1: begin
              outside_latch_enable <= w_data[`BIT_OUTSIDE_LATCH_ENABLE];
              within_latch_enable <= w_data[`BIT_WITHIN_LATCH_ENABLE];
            end
            `ADDR_IRQ_MASK: irq_mask <= w_data[3:0];
            `ADDR_IRQ_ROUTE: irq_route <= w_data[3:0];
            default: begin
            end
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // event flags; a new event in the clearing cycle wins over the clear
  // latched outside flag cleared by source read
  event_flag_cell i_outside_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .condition(outside_condition),
    .latch_enable(outside_latch_enable),
    .clear_read(rd_src1),
    .flag(outside_event_active)
  );

  // latched within flag cleared by source read
  event_flag_cell i_within_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .condition(within_condition),
    .latch_enable(within_latch_enable),
    .clear_read(rd_src2),
    .flag(within_event_active)
  );

  event_flag_cell i_orientation_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .condition(orientation_change),
    .latch_enable(1'b1),
    .clear_read(rd_orientation_engine),
    .flag(new_orientation_indicator)
  );

  // a read and a fresh edge in one cycle keep the bit, so no event is lost
  assign next_irq_status = (events & ~prev_events) | (irq_status & {4{!rd_irq_status}});
  assign next_irq = |active_irq;
  // pins are split by route so each source can go to either pin
  assign next_pin_a = |(active_irq & ~irq_route);
  assign next_pin_b = |(active_irq & irq_route);

  // sticky interrupt status, cleared by its own read, and pin routing
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_events <= 4'h0;
      irq_status <= 4'h0;
      irq <= 1'b0;
      interrupt_pin_a <= 1'b0;
      interrupt_pin_b <= 1'b0;
    end else begin
      prev_events <= events;
      irq_status <= next_irq_status;
      irq <= next_irq;
      interrupt_pin_a <= next_pin_a;
      interrupt_pin_b <= next_pin_b;
    end
  end

endmodule // event_status_aggregator_upper

// one event flag: follows its condition, or holds it until a clearing read when latched
module event_flag_cell (
  input wire aclk,
  input wire aresetn,
  input wire condition,
  input wire latch_enable,
  input wire clear_read,
  output reg flag
);

  // set wins over a clear in the same cycle; a read while the condition stands does not stick
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else if (latch_enable) begin
      flag <= condition || (flag && !clear_read);
    end else begin
      flag <= condition;
    end
  end

endmodule // event_flag_cell

// ===== rtl/event_status_aggregator_upper_regs.vh
// register offsets, field positions and reset values for the event status aggregator
// assumes byte addresses on an 8-bit axi4-lite address bus, one aligned word per register
`ifndef EVENT_STATUS_AGGREGATOR_UPPER_REGS_VH
`define EVENT_STATUS_AGGREGATOR_UPPER_REGS_VH

`define ADDR_INTERRUPT_EVENT_STATUS 8'h00
`define ADDR_BUFFER_STATUS 8'h04
`define ADDR_SYSTEM_MODE 8'h08
`define ADDR_BUFFER_CONFIG1 8'h0C
`define ADDR_DETECTOR_CONFIG1 8'h10
`define ADDR_DETECTOR_SOURCE1 8'h14
`define ADDR_DETECTOR_SOURCE2 8'h18
`define ADDR_ORIENTATION_STATUS 8'h1C
`define ADDR_IRQ_STATUS 8'h20
`define ADDR_IRQ_MASK 8'h24
`define ADDR_IRQ_ROUTE 8'h28

// interrupt_event_status bit positions
`define BIT_BUFFER_EVENT_SUMMARY 5
`define BIT_OUTSIDE_THRESHOLD_EVENT 4
`define BIT_WITHIN_THRESHOLD_EVENT 3
`define BIT_ORIENTATION_CHANGE_EVENT 2

// buffer_status bits
`define BIT_BUFFER_WATERMARK 0
`define BIT_BUFFER_OVERFLOW 1
`define BIT_BUFFER_FULL 2
// system_mode bit
`define BIT_BUFFER_GATE_ERROR 0
// detector_config_reg1 bits
`define BIT_OUTSIDE_LATCH_ENABLE 0
`define BIT_WITHIN_LATCH_ENABLE 1

// buffer mode field encodings
`define BUFFER_MODE_DISABLED 2'h0
`define BUFFER_MODE_TRIGGERED 2'h3

// reset values
`define RESET_BUFFER_MODE 2'h0
`define RESET_LATCH_ENABLES 2'h0
`define RESET_IRQ_MASK 4'h0
`define RESET_IRQ_ROUTE 4'h0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== tb/event_status_aggregator_upper_assertions.sv
// port checker for the event status aggregator
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module esa_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq,
  input wire interrupt_pin_a,
  input wire interrupt_pin_b,
  input wire [1:0] s_axi_bresp,
  input wire [1:0] s_axi_rresp,
  input wire [1:0] buffer_mode,
  input wire [7:0] s_axi_araddr,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire take = s_axi_arvalid && s_axi_arready;
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("b dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("r dropped");
  r_answer_a: assert property (take |=> s_axi_rvalid)
    else $error("no read answer");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar open");
  map_err_a: assert property (take && s_axi_araddr > 8'h28 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read");
  status_pos_a: assert property (take && s_axi_araddr == 8'h00 |=> (s_axi_rdata & 32'hFFFFFFC3) == 32'h0)
    else $error("stray status bit");
  buf_off_a: assert property (take && s_axi_araddr == 8'h00 && buffer_mode == 2'h0 |=> !s_axi_rdata[5])
    else $error("summary while off");
  pin_split_a: assert property (irq == (interrupt_pin_a || interrupt_pin_b))
    else $error("pins disagree");
  cover property (take && s_axi_araddr == 8'h1C);
  cover property (irq && interrupt_pin_b);
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule // esa_checker
bind event_status_aggregator_upper esa_checker i_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .irq(irq),
  .interrupt_pin_a(interrupt_pin_a),
  .interrupt_pin_b(interrupt_pin_b),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_rresp(s_axi_rresp),
  .buffer_mode(buffer_mode),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_rdata(s_axi_rdata)
);

// ===== tb/host_model.sv
// host model: axi4-lite master, one write and one read at a time
// assumes the slave shares aclk; released address and data lines show inverted values
`timescale 1ns/1ns
module host_model (
  input wire aclk,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_bresp,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  output reg s_axi_awvalid = 1'b0,
  output reg s_axi_wvalid = 1'b0,
  output reg s_axi_bready = 1'b0,
  output reg s_axi_arvalid = 1'b0,
  output reg s_axi_rready = 1'b0,
  output reg [7:0] s_axi_awaddr = 8'h00,
  output reg [7:0] s_axi_araddr = 8'h00,
  output reg [31:0] s_axi_wdata = 32'h0,
  output reg [3:0] s_axi_wstrb = 4'h0
);
  // slow holds bready and rready low until the answer shows
  reg slow = 1'b0;
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'h3, !slow};
      do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
        if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
        if (s_axi_bvalid) s_axi_bready <= !s_axi_bready;
      end while (!(s_axi_bvalid && s_axi_bready));
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, !slow};
      do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        if (s_axi_rvalid) s_axi_rready <= !s_axi_rready;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask
endmodule // host_model

// ===== tb/event_status_aggregator_upper_tb.sv
// bench for the event status aggregator: host model on the bus, events driven here
// assumes flags follow inputs within one edge and pins within two more
`timescale 1ns/1ns
module event_status_aggregator_upper_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg buffer_watermark_flag = 1'b0, buffer_overflow_flag = 1'b0, buffer_gate_error_flag = 1'b0;
  reg buffer_full_flag = 1'b0, outside_condition = 1'b0, within_condition = 1'b0, orientation_change = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, interrupt_pin_a, interrupt_pin_b;
  wire s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire [1:0] s_axi_bresp, s_axi_rresp, buffer_mode;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  integer failures = 0, n_checks = 0, i;
  reg [31:0] d;
  reg [1:0] r;
  always #5 aclk = ~aclk;
  event_status_aggregator_upper i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .buffer_watermark_flag(buffer_watermark_flag), .buffer_overflow_flag(buffer_overflow_flag),
    .buffer_gate_error_flag(buffer_gate_error_flag), .buffer_full_flag(buffer_full_flag),
    .outside_condition(outside_condition), .within_condition(within_condition),
    .orientation_change(orientation_change), .buffer_mode(buffer_mode), .irq(irq),
    .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b)
  );
  host_model i_host (
    .aclk(aclk), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bresp(s_axi_bresp),
    .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_rready(s_axi_rready), .s_axi_awaddr(s_axi_awaddr), .s_axi_araddr(s_axi_araddr),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb)
  );
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [7:0] a, input [31:0] exp);
    begin
      i_host.rd(a, d, r);
      chk(d, exp);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (6000) @(posedge aclk);
    failures = failures + 1;
    conclude;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h40, 32'h0);
    chk(r, 32'h2);
    buffer_watermark_flag <= 1'b1;
    rc(8'h00, 32'h0);
    i_host.wr(8'h0C, 32'h1);
    rc(8'h00, 32'h20);
    rc(8'h04, 32'h1);
    buffer_watermark_flag <= 1'b0;
    buffer_gate_error_flag <= 1'b1;
    rc(8'h08, 32'h1);
    rc(8'h00, 32'h20);
    buffer_gate_error_flag <= 1'b0;
    buffer_overflow_flag <= 1'b1;
    rc(8'h04, 32'h2);
    rc(8'h00, 32'h20);
    buffer_overflow_flag <= 1'b0;
    rc(8'h00, 32'h0);
    i_host.slow = 1'b1;
    rc(8'h20, 32'h8);
    i_host.wr(8'h24, 32'hF);
    i_host.wr(8'h0C, 32'h3);
    buffer_watermark_flag <= 1'b1;
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h1);
    outside_condition <= 1'b1;
    rc(8'h00, 32'h10);
    outside_condition <= 1'b0;
    rc(8'h20, 32'h4);
    buffer_full_flag <= 1'b1;
    rc(8'h00, 32'h20);
    chk({irq, interrupt_pin_b, interrupt_pin_a}, 32'h5);
    i_host.wr(8'h28, 32'h8);
    repeat (2) @(posedge aclk);
    chk({irq, interrupt_pin_b, interrupt_pin_a}, 32'h6);
    rc(8'h20, 32'h8);
    buffer_full_flag <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({irq, interrupt_pin_b, interrupt_pin_a}, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      {outside_condition, within_condition} <= 2'h2 >> i;
      rc(8'h00, 32'h10 >> i);
      rc(8'(8'h14 + 4 * i), 32'h1);
      {outside_condition, within_condition} <= 2'h0;
      rc(8'h00, 32'h0);
      i_host.wr(8'h10, 32'h1 << i);
      {outside_condition, within_condition} <= 2'h2 >> i;
      @(posedge aclk) {outside_condition, within_condition} <= 2'h0;
      rc(8'h00, 32'h10 >> i);
      rc(8'h00, 32'h10 >> i);
      rc(8'(8'h14 + 4 * i), 32'h1);
      rc(8'h00, 32'h0);
    end
    orientation_change <= 1'b1;
    @(posedge aclk) orientation_change <= 1'b0;
    rc(8'h00, 32'h4);
    rc(8'h00, 32'h4);
    rc(8'h1C, 32'h1);
    rc(8'h00, 32'h0);
    conclude;
  end
endmodule // event_status_aggregator_upper_tb
